/* File: peripheral_slot_decoder_tb_top.sv */
// testbench for the slot decoder
// assumes the master model and the bound checker
`timescale 1ns/100ps
module peripheral_slot_decoder_tb_top;
  import psd_pkg::*;
  logic clk = 0, rst = 1, greq = 0, got, pw, done, err, gd;
  logic [NSLOT-1:0] gate = '1, hit = '1, en, seen;
  logic [31:0] req_v, rdata, pwd, a, wd;
  logic [11:0] ofs;
  logic req, wr;
  int num_errors = 0, comparisons = 0, n;
  psd_master_model mst (.i_sys_clk(clk), .i_done(done), .o_req(req), .o_write(wr),
    .o_addr(a), .o_wdata(wd));
  psd_peripheral_slot_decoder dut (.i_sys_clk(clk), .i_rst(rst), .i_req(req), .i_write(wr),
    .i_addr(a), .i_wdata(wd), .i_clk_gate(gate), .i_ofs_hit(hit), .i_rdata_mux(32'h5a5a_0c3c),
    .i_gpio_req(greq), .i_gpio_write(1'b0), .i_gpio_addr(12'h010), .i_gpio_wdata(32'h0),
    .o_mod_en(en), .o_ofs(ofs), .o_pwrite(pw), .o_pwdata(pwd), .o_done(done), .o_err(err),
    .o_rdata(rdata), .o_gpio_direct(gd));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (|en) seen <= en;
  task automatic chk(string s, logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic acc(logic w, logic [31:0] ad, logic e, int s);
    seen = '0;
    mst.xfer(w, ad, ~ad, got);
    chk("done", 1, got);
    chk("err", e, err);
    if (!e) chk("enable", 1, seen === (128'h1 << s));
    if (!e && !w) chk("rdata", 32'h5a5a_0c3c, rdata);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000 num_errors++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 0;
    for (int s = 0; s < 64; s++) if (s inside {8, 15, 32, 33, 55, 56, 57, 59})
      acc(0, 32'h4000_0004 | (s << 12), 0, s);
    acc(0, 32'h400f_f008, 0, 15);
    acc(0, 32'h4000_0000, 1, 0);
    acc(0, 32'h4007_f000, 1, 0);
    acc(0, 32'h4008_0000, 1, 0);
    gate[55] = 0;
    acc(0, 32'h4003_7000, 1, 0);
    gate[55] = 1;
    hit[55] = 0;
    acc(0, 32'h4003_7010, 1, 0);
    hit[55] = 1;
    acc(1, 32'h4003_8020, 0, 56);
    chk("pwdata", 32'hbffc_7fdf, pwd);
    chk("ofs", 32'h020, ofs);
    chk("pwrite", 1, pw);
    acc(0, 32'h4003_8020, 0, 56);
    chk("pread", 0, pw);
    mst.xfer(0, 32'h4010_0000, 0, got);
    chk("ignored", 0, got);
    $display("bridge tests finished");
    seen = '0;
    greq = 1;
    n = 0;
    while (!done && n < 9) begin
      @(posedge clk);
      #1 n++;
    end
    greq = 0;
    chk("direct cycles", 2, n);
    chk("direct enable", 1, seen[15]);
    $display("direct test finished");
    print_verdict();
  end
endmodule

/* File: psd_decoder_props.sv */
// checker for the slot decoder ports
// assumes binding onto the decoder top module
`timescale 1ns/100ps
module psd_decoder_props (
  input wire logic                      i_sys_clk,
  input wire logic                      i_rst,
  input wire logic [psd_pkg::NSLOT-1:0] i_clk_gate,
  input wire logic [psd_pkg::NSLOT-1:0] i_ofs_hit,
  input wire logic [psd_pkg::NSLOT-1:0] o_mod_en,
  input wire logic                      o_done,
  input wire logic                      o_err,
  input wire logic                      o_gpio_direct
);
  import psd_pkg::*;
  // ==========
  // properties
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_ONEHOT: assert property ($onehot0(o_mod_en)) else $error("enables overlap");
  AST_ERRDONE: assert property (o_err |-> o_done) else $error("stray error");
  AST_PULSE: assert property (o_done |=> !o_done) else $error("done too long");
  AST_DIRECT: assert property (o_gpio_direct |-> o_mod_en[15] ##1 o_done && !o_err)
    else $error("direct path slow");
  AST_GATE: assert property ($rose(o_mod_en[55]) |-> $past(i_clk_gate[55]))
    else $error("gated slot enabled");
  AST_PIT: assert property ($rose(o_mod_en[55]) |-> ##3 o_done) else $error("slot late");
  AST_HIT: assert property ($rose(o_mod_en[55]) ##3 o_done |-> o_err == !$past(i_ofs_hit[55]))
    else $error("offset error wrong");
  AST_EMPTY: assert property (!o_mod_en[0]) else $error("empty slot enabled");
endmodule
bind psd_peripheral_slot_decoder psd_decoder_props u_props (.i_sys_clk, .i_rst, .i_clk_gate,
  .i_ofs_hit, .o_mod_en, .o_done, .o_err, .o_gpio_direct);

/* File: psd_master_model.sv */
// crossbar master issuing single word transfers
// assumes calls start just after a clock edge
`timescale 1ns/100ps
module psd_master_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_done,
  output logic             o_req = 0,
  output logic             o_write = 0,
  output logic [31:0]      o_addr = 0,
  output logic [31:0]      o_wdata = 0
);
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic got);
    got = 0;
    @(posedge i_sys_clk);
    #1 o_req = 1;
    o_write = w;
    o_addr = a;
    o_wdata = d;
    for (int n = 0; n < 12 && !got; n++) begin
      @(posedge i_sys_clk);
      #1 got = i_done;
    end
    // released bus shows inverted values
    o_req = 0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
endmodule

/* File: psd_peripheral_slot_decoder.sv */
// peripheral bridge slot decoder: window decode, module enables, error ends
// assumes a simple request/answer master and peripherals that report their own offset hits
`timescale 1ns/100ps
module psd_peripheral_slot_decoder (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_req,
  input  wire logic                       i_write,
  input  wire logic [psd_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [psd_pkg::NSLOT-1:0]  i_clk_gate,
  input  wire logic [psd_pkg::NSLOT-1:0]  i_ofs_hit,
  input  wire logic [31:0]                i_rdata_mux,
  input  wire logic                       i_gpio_req,
  input  wire logic                       i_gpio_write,
  input  wire logic [psd_pkg::OFS_W-1:0]  i_gpio_addr,
  input  wire logic [31:0]                i_gpio_wdata,
  output logic      [psd_pkg::NSLOT-1:0]  o_mod_en,
  output logic      [psd_pkg::OFS_W-1:0]  o_ofs,
  output logic                            o_pwrite,
  output logic      [31:0]                o_pwdata,
  output logic                            o_done,
  output logic                            o_err,
  output logic      [31:0]                o_rdata,
  output logic                            o_gpio_direct
);
  import psd_pkg::*;

  // =========================================================
  // slot decode
  function automatic logic slot_impl(input logic [7:0] s);
    slot_impl = (s == SLOT_DMA) || (s == SLOT_GPIO) || (s == SLOT_FLASH) ||
                (s == SLOT_DMAMUX) || (s == SLOT_PIT) || (s == SLOT_TPM0) ||
                (s == SLOT_TPM1) || (s == SLOT_ADC);
  endfunction

  logic        in_win;
  logic [7:0]  raw_slot;
  logic [6:0]  slot;
  logic        slot_ok;
  logic        bridge_req;
  logic        gpio_core;

  always_comb begin
    in_win   = (i_addr[31:20] == WIN_BASE_HI);
    raw_slot = i_addr[19:12];
    if (raw_slot == SLOT_ALIAS) begin
      slot = SLOT_GPIO[6:0];
    end else begin
      slot = raw_slot[6:0];
    end
    slot_ok    = ((raw_slot <= SLOT_LAST) || (raw_slot == SLOT_ALIAS)) &&
                 slot_impl({1'b0, slot}) && i_clk_gate[slot];
    gpio_core  = i_gpio_req && i_clk_gate[SLOT_GPIO[6:0]];
    bridge_req = i_req && in_win && !gpio_core;
  end

  // =========================================================
  // transfer sequencer
  psd_state_t              state;
  psd_state_t              next_state;
  logic [NSLOT-1:0]        next_mod_en;
  logic [OFS_W-1:0]        next_ofs;
  logic                    next_pwrite;
  logic [31:0]             next_pwdata;
  logic                    next_done;
  logic                    next_err;
  logic [31:0]             next_rdata;
  logic                    next_gpio_direct;
  logic [1:0]              wait_cnt;
  logic [1:0]              next_wait_cnt;

  always_comb begin
    next_state       = state;
    next_mod_en      = o_mod_en;
    next_ofs         = o_ofs;
    next_pwrite      = o_pwrite;
    next_pwdata      = o_pwdata;
    next_done        = 1'b0;
    next_err         = 1'b0;
    next_rdata       = o_rdata;
    next_gpio_direct = 1'b0;
    next_wait_cnt    = wait_cnt;
    unique case (state)
      PSD_IDLE: begin
        next_mod_en = '0;
        if (gpio_core) begin
          // direct core path: enable for one cycle, done on the next, no bridge wait
          next_mod_en[SLOT_GPIO[6:0]] = 1'b1;
          next_ofs         = i_gpio_addr;
          next_pwrite      = i_gpio_write;
          next_pwdata      = i_gpio_wdata;
          next_gpio_direct = 1'b1;
          next_state       = PSD_DATA;
        end else if (bridge_req) begin
          if (slot_ok) begin
            next_mod_en[slot] = 1'b1;
            next_ofs          = i_addr[OFS_W-1:0];
            next_pwrite       = i_write;
            next_pwdata       = i_wdata;
            next_wait_cnt     = BRIDGE_WAIT;
            next_state        = PSD_WAIT;
          end else begin
            next_done = 1'b1;
            next_err  = 1'b1;
          end
        end
      end
      PSD_WAIT: begin
        if (wait_cnt == 2'h0) begin
          next_state = PSD_DATA;
        end else begin
          next_wait_cnt = wait_cnt - 2'h1;
        end
      end
      PSD_DATA: begin
        next_done   = 1'b1;
        next_err    = ~|(o_mod_en & i_ofs_hit);
        next_rdata  = o_pwrite ? 32'h0000_0000 : i_rdata_mux;
        next_mod_en = '0;
        next_state  = PSD_IDLE;
      end
      default: begin
        next_mod_en = '0;
        next_state  = PSD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state         <= PSD_IDLE;
      o_mod_en      <= '0;
      o_ofs         <= '0;
      o_pwrite      <= 1'b0;
      o_pwdata      <= 32'h0000_0000;
      o_done        <= 1'b0;
      o_err         <= 1'b0;
      o_rdata       <= 32'h0000_0000;
      o_gpio_direct <= 1'b0;
      wait_cnt      <= 2'h0;
    end else begin
      state         <= next_state;
      o_mod_en      <= next_mod_en;
      o_ofs         <= next_ofs;
      o_pwrite      <= next_pwrite;
      o_pwdata      <= next_pwdata;
      o_done        <= next_done;
      o_err         <= next_err;
      o_rdata       <= next_rdata;
      o_gpio_direct <= next_gpio_direct;
      wait_cnt      <= next_wait_cnt;
    end
  end

endmodule

/* File: psd_pkg.sv */
// constants for the peripheral slot decoder
// assumes one crossbar slave port feeding the bridge, one system clock
package psd_pkg;

  localparam int          ADDR_W       = 32;
  localparam int          SLOT_W       = 8;
  localparam int          NSLOT        = 128;
  localparam int          OFS_W        = 12;
  localparam logic [11:0] WIN_BASE_HI  = 12'h400;
  localparam logic [7:0]  SLOT_DMA     = 8'h08;
  localparam logic [7:0]  SLOT_GPIO    = 8'h0f;
  localparam logic [7:0]  SLOT_FLASH   = 8'h20;
  localparam logic [7:0]  SLOT_DMAMUX  = 8'h21;
  localparam logic [7:0]  SLOT_PIT     = 8'h37;
  localparam logic [7:0]  SLOT_TPM0    = 8'h38;
  localparam logic [7:0]  SLOT_TPM1    = 8'h39;
  localparam logic [7:0]  SLOT_ADC     = 8'h3b;
  localparam logic [7:0]  SLOT_ALIAS   = 8'hff;
  localparam logic [7:0]  SLOT_LAST    = 8'h7f;
  localparam logic [1:0]  BRIDGE_WAIT  = 2'h1;

  typedef enum logic [1:0] {
    PSD_IDLE = 2'b00,
    PSD_WAIT = 2'b01,
    PSD_DATA = 2'b10
  } psd_state_t;

endpackage
